/* File: src/dwf_params.svh */
// offsets, field positions and reset values of the window geometry block
`ifndef DWF_PARAMS_SVH
`define DWF_PARAMS_SVH

// ============================================================
// register offsets (16-bit registers, byte offsets)
`define DWF_OFF_MAIN_START_LO 16'h0210
`define DWF_OFF_MAIN_START_HI 16'h0212
`define DWF_OFF_MAIN_STATUS 16'h0214
`define DWF_OFF_MAIN_LINE 16'h0216
`define DWF_OFF_INSET_START_LO 16'h0218
`define DWF_OFF_INSET_START_HI 16'h021a
`define DWF_OFF_INSET_STATUS 16'h021c
`define DWF_OFF_INSET_LINE 16'h021e
`define DWF_OFF_INSET_X_START 16'h0220
`define DWF_OFF_INSET_Y_START 16'h0222
`define DWF_OFF_INSET_X_END 16'h0224
`define DWF_OFF_INSET_Y_END 16'h0226
`define DWF_OFF_RESERVED 16'h0228

// ============================================================
// field positions
`define DWF_BIT_VDOUBLE 13
`define DWF_BIT_HDOUBLE 12
`define DWF_HI_ADDR_MSB 2
`define DWF_LINE_MSB 11
`define DWF_POS_MSB 9

// ============================================================
// reset values
`define DWF_RST_REG 16'h0000
`define DWF_RST_MAIN_STATUS 1'b1
`define DWF_RST_INSET_STATUS 1'b1

`endif

/* File: src/dwf_pkg.sv */
// types shared by the window geometry block
package dwf_pkg;
    typedef logic [18:0] dwf_addr_t;
    typedef logic [9:0] dwf_pos_t;
    typedef enum logic [1:0] {
        DWF_INSET_OFF = 2'b00,
        DWF_INSET_ON = 2'b01,
        DWF_INSET_RSVD = 2'b10,
        DWF_INSET_OVERLAY = 2'b11
    } dwf_func_e;
    typedef enum logic [1:0] {
        DWF_ROT_0 = 2'b00,
        DWF_ROT_90 = 2'b01,
        DWF_ROT_180 = 2'b10,
        DWF_ROT_270 = 2'b11
    } dwf_rot_e;
endpackage : dwf_pkg

/* File: src/dwf_window_geometry.sv */
// main and inset window fetch geometry with its configuration registers
`include "dwf_params.svh"

// Overview of operation
// - main window fetch begins at the 19-bit start address from two registers.
// - single buffer: main status 0 after address write, 1 once frame uses it.
// - double buffer, main front: main status 1 on front, 0 on back.
// - single buffer: inset status 0 after address write, 1 once frame uses it.
// - double buffer, inset front: inset status 1 on front, 0 on back.
// - main line address advances by its 12-bit byte line offset.
// - inset line address advances by its own 12-bit line offset.
// - inset fetches from its own start address, ignored when function is 00.
// - inset top-left corner sits at the 10-bit X and Y start positions.
// - inset ends at the 10-bit X and Y end positions.
// - two-bit rotation field per window selects 0, 90, 180, 270 degrees.
// - inset function 11 means inset with overlay; 00 means disabled.
module dwf_window_geometry (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // display mode controls from the mode registers
    input wire logic dblBufEn,
    input wire logic frontIsMain,
    input wire logic [1:0] insetFunc,
    input wire logic [1:0] mainRotSel,
    input wire logic [1:0] insetRotSel,
    input wire logic [18:0] backStartAddr,
    // display timing
    input wire logic frameStart,
    input wire logic lineEnd,
    input wire logic [9:0] panelX,
    input wire logic [9:0] panelY,
    // fetch geometry outputs
    output logic [18:0] mainLineAddr,
    output logic [9:0] mainSrcCol,
    output logic [18:0] insetLineAddr,
    output logic [9:0] insetSrcCol,
    output logic insetActive,
    output logic insetOverlay,
    output logic [1:0] mainRot,
    output logic [1:0] insetRot
);

    // ============================================================
    // storage
    logic [15:0] mainStartLo_r;
    logic [2:0] mainStartHi_r;
    logic [13:0] mainLine_r;
    logic [15:0] insetStartLo_r;
    logic [2:0] insetStartHi_r;
    logic [13:0] insetLine_r;
    logic [9:0] insetXs_r;
    logic [9:0] insetYs_r;
    logic [9:0] insetXe_r;
    logic [9:0] insetYe_r;
    logic mainStat_r;
    logic insetStat_r;
    logic showFront_r;
    logic mainVpar_r;
    logic insetVpar_r;
    logic [18:0] mainLineAddr_r;
    logic [18:0] insetLineAddr_r;
    logic [9:0] mainSrcCol_r;
    logic [9:0] insetSrcCol_r;
    logic insetActive_r;
    logic insetOverlay_r;
    logic [1:0] mainRot_r;
    logic [1:0] insetRot_r;
    logic [15:0] regRdata_r;

    // ============================================================
    // helpers
    function automatic logic [18:0] addOffset(input logic [18:0] base,
                                              input logic [11:0] off);
        addOffset = base + {7'h00, off};
    endfunction : addOffset

    function automatic logic [9:0] srcColumn(input logic [9:0] rel,
                                             input logic dbl);
        srcColumn = dbl ? {1'b0, rel[9:1]} : rel;
    endfunction : srcColumn

    // ============================================================
    // decode
    wire ceWr = ce && regWr;
    wire wrMainLo = ceWr && (regAddr == `DWF_OFF_MAIN_START_LO);
    wire wrMainHi = ceWr && (regAddr == `DWF_OFF_MAIN_START_HI);
    wire wrMainLine = ceWr && (regAddr == `DWF_OFF_MAIN_LINE);
    wire wrInsetLo = ceWr && (regAddr == `DWF_OFF_INSET_START_LO);
    wire wrInsetHi = ceWr && (regAddr == `DWF_OFF_INSET_START_HI);
    wire wrInsetLine = ceWr && (regAddr == `DWF_OFF_INSET_LINE);
    wire wrXs = ceWr && (regAddr == `DWF_OFF_INSET_X_START);
    wire wrYs = ceWr && (regAddr == `DWF_OFF_INSET_Y_START);
    wire wrXe = ceWr && (regAddr == `DWF_OFF_INSET_X_END);
    wire wrYe = ceWr && (regAddr == `DWF_OFF_INSET_Y_END);
    wire mainAddrWr = wrMainLo || wrMainHi;
    wire insetAddrWr = wrInsetLo || wrInsetHi;

    wire [18:0] mainStart = {mainStartHi_r, mainStartLo_r};
    wire [18:0] insetStart = {insetStartHi_r, insetStartLo_r};
    wire mainVdbl = mainLine_r[`DWF_BIT_VDOUBLE];
    wire mainHdbl = mainLine_r[`DWF_BIT_HDOUBLE];
    wire insetVdbl = insetLine_r[`DWF_BIT_VDOUBLE];
    wire insetHdbl = insetLine_r[`DWF_BIT_HDOUBLE];
    wire [11:0] mainOff = mainLine_r[`DWF_LINE_MSB:0];
    wire [11:0] insetOff = insetLine_r[`DWF_LINE_MSB:0];
    wire insetEn = insetFunc != dwf_pkg::DWF_INSET_OFF;
    wire fStart = ce && frameStart;
    wire lEnd = ce && lineEnd && !frameStart;
    wire mainDblMode = dblBufEn && frontIsMain;
    wire insetDblMode = dblBufEn && !frontIsMain;
    // front/back choice for the next frame, flipped at each frame start while double buffering, else front
    wire nextFront = dblBufEn ? !showFront_r : 1'b1;
    wire [18:0] mainFrameBase =
        (mainDblMode && !nextFront) ? backStartAddr : mainStart;
    wire [18:0] insetFrameBase =
        (insetDblMode && !nextFront) ? backStartAddr : insetStart;
    wire inX = (panelX >= insetXs_r) && (panelX <= insetXe_r);
    wire inY = (panelY >= insetYs_r) && (panelY <= insetYe_r);
    // a doubled line is fetched twice, so advance on every second line
    wire mainStep = !mainVdbl || mainVpar_r;
    wire insetStep = !insetVdbl || insetVpar_r;
    wire insetLineIn = inY && insetEn;

    wire [15:0] rdMux =
        (regAddr == `DWF_OFF_MAIN_START_LO) ? mainStartLo_r :
        (regAddr == `DWF_OFF_MAIN_START_HI) ? {13'h0000, mainStartHi_r} :
        (regAddr == `DWF_OFF_MAIN_STATUS) ? {15'h0000, mainStat_r} :
        (regAddr == `DWF_OFF_MAIN_LINE) ? {2'b00, mainLine_r} :
        (regAddr == `DWF_OFF_INSET_START_LO) ? insetStartLo_r :
        (regAddr == `DWF_OFF_INSET_START_HI) ? {13'h0000, insetStartHi_r} :
        (regAddr == `DWF_OFF_INSET_STATUS) ? {15'h0000, insetStat_r} :
        (regAddr == `DWF_OFF_INSET_LINE) ? {2'b00, insetLine_r} :
        (regAddr == `DWF_OFF_INSET_X_START) ? {6'h00, insetXs_r} :
        (regAddr == `DWF_OFF_INSET_Y_START) ? {6'h00, insetYs_r} :
        (regAddr == `DWF_OFF_INSET_X_END) ? {6'h00, insetXe_r} :
        (regAddr == `DWF_OFF_INSET_Y_END) ? {6'h00, insetYe_r} :
        16'h0000;

    // ============================================================
    // configuration registers; the reserved offset takes no write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainStartLo_r <= `DWF_RST_REG;
            mainStartHi_r <= 3'h0;
            mainLine_r <= 14'h0000;
            insetStartLo_r <= `DWF_RST_REG;
            insetStartHi_r <= 3'h0;
            insetLine_r <= 14'h0000;
        end else begin
            if (wrMainLo) mainStartLo_r <= regWdata;
            if (wrMainHi) mainStartHi_r <= regWdata[`DWF_HI_ADDR_MSB:0];
            if (wrMainLine) mainLine_r <= regWdata[13:0];
            if (wrInsetLo) insetStartLo_r <= regWdata;
            if (wrInsetHi) insetStartHi_r <= regWdata[`DWF_HI_ADDR_MSB:0];
            if (wrInsetLine) insetLine_r <= regWdata[13:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            insetXs_r <= 10'h000;
            insetYs_r <= 10'h000;
            insetXe_r <= 10'h000;
            insetYe_r <= 10'h000;
        end else begin
            if (wrXs) insetXs_r <= regWdata[`DWF_POS_MSB:0];
            if (wrYs) insetYs_r <= regWdata[`DWF_POS_MSB:0];
            if (wrXe) insetXe_r <= regWdata[`DWF_POS_MSB:0];
            if (wrYe) insetYe_r <= regWdata[`DWF_POS_MSB:0];
        end
    end

    // read data stands after a read strobe taken with ce high, until the next cycle with ce high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= 16'h0000;
        end else if (ce) begin
            regRdata_r <= regRd ? rdMux : 16'h0000;
        end
    end

    // ============================================================
    // status; for a window not double buffered, an address write in a frame-start cycle misses that frame,
    // so the write wins and the status stays pending
    wire mainStatNxt = mainDblMode ? nextFront :
                       mainAddrWr ? 1'b0 : 1'b1;
    wire insetStatNxt = insetDblMode ? nextFront :
                        insetAddrWr ? 1'b0 : 1'b1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainStat_r <= `DWF_RST_MAIN_STATUS;
            insetStat_r <= `DWF_RST_INSET_STATUS;
            showFront_r <= 1'b1;
        end else if (fStart) begin
            mainStat_r <= mainStatNxt;
            insetStat_r <= insetStatNxt;
            showFront_r <= nextFront;
        end else begin
            if (mainAddrWr && !dblBufEn) mainStat_r <= 1'b0;
            if (insetAddrWr && !dblBufEn) insetStat_r <= 1'b0;
        end
    end

    // ============================================================
    // line address walkers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainLineAddr_r <= 19'h00000;
            mainVpar_r <= 1'b0;
        end else if (fStart) begin
            mainLineAddr_r <= mainFrameBase;
            mainVpar_r <= 1'b0;
        end else if (lEnd) begin
            if (mainStep) begin
                mainLineAddr_r <= addOffset(mainLineAddr_r, mainOff);
            end
            mainVpar_r <= mainVdbl && !mainVpar_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            insetLineAddr_r <= 19'h00000;
            insetVpar_r <= 1'b0;
        end else if (fStart) begin
            insetLineAddr_r <= insetEn ? insetFrameBase : 19'h00000;
            insetVpar_r <= 1'b0;
        end else if (lEnd && insetLineIn) begin
            if (insetStep) begin
                insetLineAddr_r <= addOffset(insetLineAddr_r, insetOff);
            end
            insetVpar_r <= insetVdbl && !insetVpar_r;
        end
    end

    // ============================================================
    // per-pixel placement
    wire [9:0] insetRel = panelX - insetXs_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainSrcCol_r <= 10'h000;
            insetSrcCol_r <= 10'h000;
            insetActive_r <= 1'b0;
            insetOverlay_r <= 1'b0;
        end else if (ce) begin
            mainSrcCol_r <= srcColumn(panelX, mainHdbl);
            insetSrcCol_r <= inX ? srcColumn(insetRel, insetHdbl) : 10'h000;
            insetActive_r <= insetEn && inX && inY;
            insetOverlay_r <= insetFunc == dwf_pkg::DWF_INSET_OVERLAY;
        end
    end

    // rotation follows the frame, never changing mid-frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mainRot_r <= dwf_pkg::DWF_ROT_0;
            insetRot_r <= dwf_pkg::DWF_ROT_0;
        end else if (fStart) begin
            mainRot_r <= mainRotSel;
            insetRot_r <= insetRotSel;
        end
    end

    assign regRdata = regRdata_r;
    assign mainLineAddr = mainLineAddr_r;
    assign mainSrcCol = mainSrcCol_r;
    assign insetLineAddr = insetLineAddr_r;
    assign insetSrcCol = insetSrcCol_r;
    assign insetActive = insetActive_r;
    assign insetOverlay = insetOverlay_r;
    assign mainRot = mainRot_r;
    assign insetRot = insetRot_r;

    // ============================================================
    // checks
    AST_MAIN_WR_PEND: assert property (
        @(posedge clk) disable iff (!rst_n)
        mainAddrWr && !dblBufEn |=> !mainStat_r
    ) else $error("main status not pending after address write");

    AST_MAIN_FRAME_USE: assert property (
        @(posedge clk) disable iff (!rst_n)
        fStart && !dblBufEn && !mainAddrWr |=>
            mainStat_r && mainLineAddr_r == $past(mainStart)
    ) else $error("main frame did not take latest start address");

    AST_MAIN_DBL_FLIP: assert property (
        @(posedge clk) disable iff (!rst_n)
        fStart && dblBufEn && frontIsMain |=>
            showFront_r != $past(showFront_r) &&
            mainStat_r == showFront_r &&
            mainLineAddr_r ==
                (mainStat_r ? $past(mainStart) : $past(backStartAddr))
    ) else $error("main status does not follow shown buffer");

    AST_INSET_DBL_BACK: assert property (
        @(posedge clk) disable iff (!rst_n)
        fStart && dblBufEn && !frontIsMain && insetEn && showFront_r |=>
            !insetStat_r && insetLineAddr_r == $past(backStartAddr)
    ) else $error("inset back buffer not shown with status 0");

    AST_INSET_WR_PEND: assert property (
        @(posedge clk) disable iff (!rst_n)
        insetAddrWr && !dblBufEn ##1 !fStart[*2] |-> !insetStat_r
    ) else $error("inset status lost pending state");

    AST_MAIN_LINE_STEP: assert property (
        @(posedge clk) disable iff (!rst_n)
        lEnd && !mainVdbl |=>
            mainLineAddr_r == addOffset($past(mainLineAddr_r),
                                        $past(mainOff))
    ) else $error("main line address did not step by offset");

    AST_VDBL_PAIR: assert property (
        @(posedge clk) disable iff (!rst_n)
        lEnd && mainVdbl && !mainVpar_r && !fStart |=>
            $stable(mainLineAddr_r)
    ) else $error("doubled line advanced too early");

    AST_INSET_OFF: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && insetFunc == dwf_pkg::DWF_INSET_OFF |=>
            !insetActive_r ##0 (!$past(frameStart) || insetLineAddr_r == 0)
    ) else $error("disabled inset still active");

    AST_INSET_EDGE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && insetEn && panelX == insetXs_r && inY |=>
            insetActive_r && insetSrcCol_r == 10'h000
    ) else $error("inset corner not placed at start position");

    AST_RSVD_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && regRd && regAddr == `DWF_OFF_RESERVED |=> regRdata_r == 0
    ) else $error("reserved register read not zero");

endmodule : dwf_window_geometry

/* File: tb/test_dwf_window_geometry.sv */
// self-checking bench for the window fetch geometry block
`include "dwf_params.svh"

module test_dwf_window_geometry;
    timeunit 1ns;
    timeprecision 1ps;

    // ============================================================
    // signals
    logic clk;
    logic rst_n;
    logic ce;
    logic [15:0] regAddr;
    logic [15:0] regWdata;
    logic regWr;
    logic regRd;
    logic [15:0] regRdata;
    logic dblBufEn;
    logic frontIsMain;
    logic [1:0] insetFunc;
    logic [1:0] mainRotSel;
    logic [1:0] insetRotSel;
    logic [18:0] backStartAddr;
    logic frameStart;
    logic lineEnd;
    logic [9:0] panelX;
    logic [9:0] panelY;
    logic [18:0] mainLineAddr;
    logic [9:0] mainSrcCol;
    logic [18:0] insetLineAddr;
    logic [9:0] insetSrcCol;
    logic insetActive;
    logic insetOverlay;
    logic [1:0] mainRot;
    logic [1:0] insetRot;
    int err_count;
    int checks_done;
    int cycles;

    dwf_window_geometry i_dut (
        .clk(clk), .rst_n(rst_n), .ce(ce),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata),
        .dblBufEn(dblBufEn), .frontIsMain(frontIsMain),
        .insetFunc(insetFunc), .mainRotSel(mainRotSel),
        .insetRotSel(insetRotSel), .backStartAddr(backStartAddr),
        .frameStart(frameStart), .lineEnd(lineEnd),
        .panelX(panelX), .panelY(panelY),
        .mainLineAddr(mainLineAddr), .mainSrcCol(mainSrcCol),
        .insetLineAddr(insetLineAddr), .insetSrcCol(insetSrcCol),
        .insetActive(insetActive), .insetOverlay(insetOverlay),
        .mainRot(mainRot), .insetRot(insetRot)
    );

    // ============================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // whole run is well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_count++;
            $display("CHECK FAILED timeout expected 0 seen 1");
            test_done();
        end
    end

    // ============================================================
    // shared tasks
    task automatic chk(input string what, input logic [18:0] exp,
            input logic [18:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rdchk(input string what, input logic [15:0] a,
            input logic [15:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(what, {3'h0, exp}, {3'h0, regRdata});
    endtask : rdchk

    // one-cycle frame or line pulse; returns just after it is taken
    task automatic pulse(input bit isFrame);
        @(posedge clk);
        frameStart <= isFrame;
        lineEnd <= !isFrame;
        @(posedge clk);
        frameStart <= 1'b0;
        lineEnd <= 1'b0;
        #1;
    endtask : pulse

    task automatic place(input logic [9:0] x, input logic [9:0] y);
        @(posedge clk);
        panelX <= x;
        panelY <= y;
        repeat (3) @(posedge clk);
        #1;
    endtask : place

    // ============================================================
    // scenarios
    task automatic test_regs();
        rdchk("main status reset", `DWF_OFF_MAIN_STATUS, 16'h0001);
        rdchk("inset status reset", `DWF_OFF_INSET_STATUS, 16'h0001);
        rdchk("x end reset", `DWF_OFF_INSET_X_END, 16'h0000);
        wr(`DWF_OFF_MAIN_START_HI, 16'hffff);
        rdchk("main start hi", `DWF_OFF_MAIN_START_HI, 16'h0007);
        wr(`DWF_OFF_MAIN_LINE, 16'hffff);
        rdchk("main line reg", `DWF_OFF_MAIN_LINE, 16'h3fff);
        wr(`DWF_OFF_INSET_LINE, 16'hffff);
        rdchk("inset line reg", `DWF_OFF_INSET_LINE, 16'h3fff);
        wr(`DWF_OFF_INSET_X_START, 16'hffff);
        rdchk("x start reg", `DWF_OFF_INSET_X_START, 16'h03ff);
        wr(`DWF_OFF_INSET_Y_END, 16'hffff);
        rdchk("y end reg", `DWF_OFF_INSET_Y_END, 16'h03ff);
        rdchk("reserved reg", `DWF_OFF_RESERVED, 16'h0000);
        rdchk("unmapped reg", 16'h0300, 16'h0000);
        wr(`DWF_OFF_INSET_Y_START, 16'h0155);
        rdchk("y start reg", `DWF_OFF_INSET_Y_START, 16'h0155);
        @(posedge clk);
        #1;
        chk("read data after", 19'h0, {3'h0, regRdata});
    endtask : test_regs

    task automatic test_status();
        // settle the pending state left by the register checks first
        pulse(1'b1);
        wr(`DWF_OFF_MAIN_START_LO, 16'h1000);
        rdchk("main status written", `DWF_OFF_MAIN_STATUS, 16'h0000);
        pulse(1'b1);
        rdchk("main status used", `DWF_OFF_MAIN_STATUS, 16'h0001);
        wr(`DWF_OFF_MAIN_STATUS, 16'h0000);
        rdchk("status not writable", `DWF_OFF_MAIN_STATUS, 16'h0001);
        wr(`DWF_OFF_INSET_START_HI, 16'h0002);
        rdchk("inset status written", `DWF_OFF_INSET_STATUS, 16'h0);
        rdchk("main status kept", `DWF_OFF_MAIN_STATUS, 16'h0001);
        pulse(1'b1);
        rdchk("inset status used", `DWF_OFF_INSET_STATUS, 16'h1);
    endtask : test_status

    task automatic test_main_lines();
        wr(`DWF_OFF_MAIN_START_HI, 16'h0001);
        wr(`DWF_OFF_MAIN_START_LO, 16'h2340);
        wr(`DWF_OFF_MAIN_LINE, 16'h00f0);
        pulse(1'b1);
        chk("main frame addr", 19'h12340, mainLineAddr);
        pulse(1'b0);
        chk("main line step", 19'h12430, mainLineAddr);
        wr(`DWF_OFF_MAIN_LINE, 16'h20f0);
        pulse(1'b1);
        pulse(1'b0);
        chk("vdouble first line", 19'h12340, mainLineAddr);
        pulse(1'b0);
        chk("vdouble second line", 19'h12430, mainLineAddr);
        wr(`DWF_OFF_MAIN_LINE, 16'h10f0);
        place(10'h0c9, 10'h000);
        chk("hdouble column", 19'h00064, {9'h0, mainSrcCol});
        wr(`DWF_OFF_MAIN_LINE, 16'h00f0);
        place(10'h0c9, 10'h000);
        chk("plain column", 19'h000c9, {9'h0, mainSrcCol});
    endtask : test_main_lines

    task automatic test_double();
        @(posedge clk);
        dblBufEn <= 1'b1;
        frontIsMain <= 1'b1;
        pulse(1'b1);
        chk("back addr shown", 19'h40000, mainLineAddr);
        rdchk("main back shown", `DWF_OFF_MAIN_STATUS, 16'h0000);
        pulse(1'b1);
        chk("front addr shown", 19'h12340, mainLineAddr);
        rdchk("main front shown", `DWF_OFF_MAIN_STATUS, 16'h0001);
        @(posedge clk);
        frontIsMain <= 1'b0;
        pulse(1'b1);
        rdchk("inset back shown", `DWF_OFF_INSET_STATUS, 16'h0000);
        rdchk("main as single", `DWF_OFF_MAIN_STATUS, 16'h0001);
        pulse(1'b1);
        rdchk("inset front shown", `DWF_OFF_INSET_STATUS, 16'h0001);
        @(posedge clk);
        dblBufEn <= 1'b0;
        frontIsMain <= 1'b1;
    endtask : test_double

    task automatic test_inset();
        wr(`DWF_OFF_INSET_X_START, 16'h0010);
        wr(`DWF_OFF_INSET_Y_START, 16'h0020);
        wr(`DWF_OFF_INSET_X_END, 16'h0030);
        wr(`DWF_OFF_INSET_Y_END, 16'h0040);
        wr(`DWF_OFF_INSET_START_HI, 16'h0000);
        wr(`DWF_OFF_INSET_START_LO, 16'h0800);
        wr(`DWF_OFF_INSET_LINE, 16'h0050);
        place(10'h020, 10'h030);
        pulse(1'b1);
        chk("inset frame addr", 19'h00800, insetLineAddr);
        pulse(1'b0);
        chk("inset line step", 19'h00850, insetLineAddr);
        chk("main independent", 19'h12430, mainLineAddr);
        chk("inset inside", 19'h1, {18'h0, insetActive});
        chk("inset column", 19'h10, {9'h0, insetSrcCol});
        place(10'h030, 10'h040);
        chk("inset end corner", 19'h1, {18'h0, insetActive});
        place(10'h031, 10'h040);
        chk("past x end", 19'h0, {18'h0, insetActive});
        place(10'h00f, 10'h020);
        chk("before x start", 19'h0, {18'h0, insetActive});
        place(10'h020, 10'h041);
        pulse(1'b0);
        chk("no step outside", 19'h00850, insetLineAddr);
        chk("past y end", 19'h0, {18'h0, insetActive});
        for (int f = 0; f < 4; f++) begin
            @(posedge clk);
            insetFunc <= 2'(f);
            place(10'h020, 10'h030);
            chk("func active", 19'(f != 0), {18'h0, insetActive});
            chk("func overlay", 19'(f == 3), {18'h0, insetOverlay});
        end
        @(posedge clk);
        insetFunc <= dwf_pkg::DWF_INSET_OFF;
        pulse(1'b1);
        chk("inset off addr", 19'h0, insetLineAddr);
        @(posedge clk);
        insetFunc <= dwf_pkg::DWF_INSET_OVERLAY;
    endtask : test_inset

    task automatic test_rot();
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            mainRotSel <= 2'(r);
            insetRotSel <= 2'(3 - r);
            pulse(1'b1);
            chk("main rotation", 19'(r), {17'h0, mainRot});
            chk("inset rotation", 19'(3 - r), {17'h0, insetRot});
        end
        // enable low must hold the latched rotation through a frame pulse
        @(posedge clk);
        ce <= 1'b0;
        mainRotSel <= 2'h1;
        pulse(1'b1);
        chk("rotation frozen", 19'h3, {17'h0, mainRot});
        @(posedge clk);
        ce <= 1'b1;
    endtask : test_rot

    // ============================================================
    // verdict
    task automatic test_done();
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    initial begin
        err_count = 0;
        checks_done = 0;
        cycles = 0;
        rst_n = 1'b0;
        ce = 1'b1;
        regAddr = 16'h0000;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        dblBufEn = 1'b0;
        frontIsMain = 1'b1;
        insetFunc = dwf_pkg::DWF_INSET_OVERLAY;
        mainRotSel = 2'h0;
        insetRotSel = 2'h0;
        backStartAddr = 19'h40000;
        frameStart = 1'b0;
        lineEnd = 1'b0;
        panelX = 10'h000;
        panelY = 10'h000;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        test_regs();
        test_status();
        test_main_lines();
        test_double();
        test_inset();
        test_rot();
        test_done();
    end
endmodule : test_dwf_window_geometry
